/* File: rtl/eisc_pkg.sv */
// ==========================================================
// constants and types of the interrupt source set/clear block
// ==========================================================
package eisc_pkg;
   localparam int unsigned SRC_W        = 16;
   localparam int unsigned EV_W         = 3;
   // printed offsets are word indexes, byte address is four times
   localparam logic [7:0]  SET_IDX      = 8'h14;
   localparam logic [7:0]  PERMIT_IDX   = 8'h16;
   localparam logic [7:0]  ADDR_SET     = 8'(SET_IDX * 4);
   localparam logic [7:0]  ADDR_PERMIT  = 8'(PERMIT_IDX * 4);
   localparam logic [7:0]  ADDR_IRQ_ST  = 8'h60;
   localparam logic [7:0]  ADDR_IRQ_EN  = 8'h64;
   localparam logic [7:0]  ADDR_IRQ_CLR = 8'h68;
   // bit 0 of both registers is reserved
   localparam logic [15:0] SRC_MASK     = 16'hFFFE;
   localparam logic [15:0] SRC_RST      = 16'h0000;
   localparam logic [15:0] PERMIT_RST   = 16'h0000;
   localparam logic [2:0]  EV_RST       = 3'h0;
   // event bit positions
   localparam int unsigned EV_CLR_DONE  = 0;
   localparam int unsigned EV_CLR_BLOCK = 1;
   localparam int unsigned EV_SET_RISE  = 2;
   localparam logic        HRESP_OKAY   = 1'h0;

   // one host write to the interrupt source register
   typedef struct packed {
      logic        valid;
      logic [15:0] bits;
   } eisc_clr_req_t;

   // pending write data phase
   typedef struct packed {
      logic       act;
      logic [7:0] addr;
   } eisc_aphase_t;
endpackage

/* File: rtl/eisc_irq_unit.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// sticky status, enable and level interrupt
// ==========================================================
module eisc_irq_unit
   import eisc_pkg::*;
#(
   parameter int unsigned N = EV_W
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [N-1:0] ev,
   input  wire logic         en_wr,
   input  wire logic         clr_wr,
   input  wire logic [N-1:0] wdata,
   output logic      [N-1:0] status,
   output logic      [N-1:0] enable,
   output logic              irq
);
   logic [N-1:0] stat_ff;
   logic [N-1:0] en_ff;
   logic         irq_ff;
   logic [N-1:0] nxt_stat;
   logic [N-1:0] nxt_en;
   logic         nxt_irq;

   // a new event beats a clear in the same cycle
   always_comb begin
      nxt_stat = clr_wr ? ((stat_ff & ~wdata) | ev) : (stat_ff | ev);
      nxt_en   = en_wr ? wdata : en_ff;
      nxt_irq  = |(nxt_stat & nxt_en);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stat_ff <= '0;
         en_ff   <= '0;
         irq_ff  <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         en_ff   <= nxt_en;
         irq_ff  <= nxt_irq;
      end
   end

   assign status = stat_ff;
   assign enable = en_ff;
   assign irq    = irq_ff;

   chk_irq_follow: assert property (@(posedge clk_sys) disable iff (rst)
      (|(stat_ff & en_ff)) == irq_ff)
      else $error("irq level does not match enabled status");
endmodule
`default_nettype wire

/* File: rtl/eisc_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// RULE_01 - a one written to a set bit sets that interrupt source bit.
// RULE_02 - a zero written to a set bit leaves that source bit alone.
// RULE_03 - reading the set register returns the live source register.
// RULE_04 - a source bit whose permit bit is zero ignores host clears.
// RULE_05 - with its permit bit one, a host one clears the source bit.
// RULE_06 - reset zeroes set and permit fields; bit 0 always reads zero.
module eisc_top
   import eisc_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic      [31:0]   hrdata,
   output logic               hreadyout,
   output logic               hresp,
   input  wire eisc_clr_req_t host_clr,
   output logic      [15:0]   irq_source,
   output logic               irq
);
   // ==========================================================
   // state
   // ==========================================================
   eisc_aphase_t  wph_ff;
   eisc_aphase_t  nxt_wph;
   logic [15:0]   src_ff;
   logic [15:0]   nxt_src;
   logic [15:0]   permit_ff;
   logic [15:0]   nxt_permit;
   logic [31:0]   rdata_ff;
   logic [31:0]   nxt_rdata;
   logic          ready_ff;
   logic          resp_ff;
   logic          req;
   logic [15:0]   set_bits;
   logic [15:0]   clr_ok;
   logic [15:0]   clr_blocked;
   logic [EV_W-1:0] ev;
   logic          wr_en_reg;
   logic          wr_clr_reg;
   logic [EV_W-1:0] irq_status;
   logic [EV_W-1:0] irq_enable;
   logic          addr_ok;
   logic [EV_W-1:0] st_view;
   logic [EV_W-1:0] en_view;

   // full-address match, only the low byte carries the offset
   function automatic logic hit(input logic [31:0] a,
                                input logic [7:0]  off);
      hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
   endfunction

   // ==========================================================
   // bus slave
   // ==========================================================
   // zero wait states, so hready is only taken as part of the
   // address-phase handshake; hsize is ignored (word access only)
   always_comb begin
      req        = hsel && htrans[1] && hready;
      // writes outside the low 256 bytes must not alias onto a register
      addr_ok    = (haddr[31:8] == 24'h000000);
      nxt_wph.act  = req && hwrite && addr_ok;
      nxt_wph.addr = haddr[7:0];
      wr_en_reg  = wph_ff.act && (wph_ff.addr == ADDR_IRQ_EN);
      wr_clr_reg = wph_ff.act && (wph_ff.addr == ADDR_IRQ_CLR);
   end

   // ==========================================================
   // source and permit registers
   // ==========================================================
   // set wins over a host clear landing in the same cycle, so no
   // controller event is lost
   always_comb begin
      set_bits = 16'h0000;
      if (wph_ff.act && (wph_ff.addr == ADDR_SET)) begin
         set_bits = hwdata[15:0] & SRC_MASK;          // see RULE_01
      end
      clr_ok      = 16'h0000;
      clr_blocked = 16'h0000;
      if (host_clr.valid) begin
         clr_ok      = host_clr.bits & permit_ff & SRC_MASK; // see RULE_05
         clr_blocked = host_clr.bits & ~permit_ff & src_ff
                       & SRC_MASK;                    // see RULE_04
      end
      // zeros in set_bits keep the old bit                see RULE_02
      nxt_src    = ((src_ff & ~clr_ok) | set_bits) & SRC_MASK;
      nxt_permit = permit_ff;
      if (wph_ff.act && (wph_ff.addr == ADDR_PERMIT)) begin
         nxt_permit = hwdata[15:0] & SRC_MASK;        // see RULE_06
      end
      ev               = EV_RST;
      ev[EV_CLR_DONE]  = |(clr_ok & src_ff);
      ev[EV_CLR_BLOCK] = |clr_blocked;
      ev[EV_SET_RISE]  = |(set_bits & ~src_ff);
   end

   // ==========================================================
   // interrupt register views for reads
   // ==========================================================
   // the interrupt unit only shows its registers, so the values
   // they take at this edge are rebuilt here; this keeps a read
   // right behind an enable or clear write in step with it
   always_comb begin
      en_view = irq_enable;
      if (wr_en_reg) begin
         en_view = hwdata[EV_W-1:0];
      end
      st_view = irq_status;
      if (wr_clr_reg) begin
         st_view = irq_status & ~hwdata[EV_W-1:0];
      end
      // an event still wins over a clear of the same cycle
      st_view = st_view | ev;
   end

   // read data uses next values so a read right behind a write
   // sees that write
   always_comb begin
      nxt_rdata = rdata_ff;
      if (req && !hwrite) begin
         if (hit(haddr, ADDR_SET)) begin
            nxt_rdata = {16'h0000, nxt_src};          // see RULE_03
         end else if (hit(haddr, ADDR_PERMIT)) begin
            nxt_rdata = {16'h0000, nxt_permit};
         end else if (hit(haddr, ADDR_IRQ_ST)) begin
            nxt_rdata = {{(32-EV_W){1'b0}}, st_view};
         end else if (hit(haddr, ADDR_IRQ_EN)) begin
            nxt_rdata = {{(32-EV_W){1'b0}}, en_view};
         end else begin
            nxt_rdata = 32'h00000000;  // unmapped and write-only
         end
      end
   end

   // registers of the block
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wph_ff    <= '0;
         src_ff    <= SRC_RST;                        // see RULE_06
         permit_ff <= PERMIT_RST;                     // see RULE_06
         rdata_ff  <= 32'h00000000;
         ready_ff  <= 1'b0;
         resp_ff   <= HRESP_OKAY;
      end else begin
         wph_ff    <= nxt_wph;
         src_ff    <= nxt_src;
         permit_ff <= nxt_permit;
         rdata_ff  <= nxt_rdata;
         ready_ff  <= 1'b1;
         resp_ff   <= HRESP_OKAY;
      end
   end

   // ==========================================================
   // interrupt
   // ==========================================================
   eisc_irq_unit #(
      .N       (EV_W)
   ) u_irq (
      .clk_sys (clk_sys),
      .rst     (rst),
      .ev      (ev),
      .en_wr   (wr_en_reg),
      .clr_wr  (wr_clr_reg),
      .wdata   (hwdata[EV_W-1:0]),
      .status  (irq_status),
      .enable  (irq_enable),
      .irq     (irq)
   );

   assign hrdata     = rdata_ff;
   assign hreadyout  = ready_ff;
   assign hresp      = resp_ff;
   assign irq_source = src_ff;

   // ==========================================================
   // checks
   // ==========================================================
   sequence s_set_write;
      wph_ff.act && (wph_ff.addr == ADDR_SET);
   endsequence

   sequence s_read_set;
      req && !hwrite && hit(haddr, ADDR_SET);
   endsequence

   sequence s_permit_write;
      wph_ff.act && (wph_ff.addr == ADDR_PERMIT);
   endsequence

   sequence s_read_permit;
      req && !hwrite && hit(haddr, ADDR_PERMIT);
   endsequence

   // one host write of the source register
   sequence s_host_clear;
      host_clr.valid;
   endsequence

   // a source bit that rises is backed by a set write; a bit that
   // falls is backed by a permitted host clear
   chk_set_ones: assert property (@(posedge clk_sys) // see RULE_01
      disable iff (rst)
      s_set_write |=> ((src_ff & $past(hwdata[15:0] & SRC_MASK))
                       == $past(hwdata[15:0] & SRC_MASK)))
      else $error("written set bit did not reach the source");

   chk_zero_keeps: assert property (@(posedge clk_sys) // see RULE_02
      disable iff (rst)
      1'b1 |=> (($past(src_ff) & ~$past(clr_ok) & ~src_ff)
                == 16'h0000))
      else $error("source bit dropped without a permitted clear");

   chk_no_stray_set: assert property (@(posedge clk_sys) // see RULE_02
      disable iff (rst)
      1'b1 |=> ((src_ff & ~$past(src_ff) & ~$past(set_bits))
                == 16'h0000))
      else $error("source bit raised without a set write");

   chk_read_live: assert property (@(posedge clk_sys) // see RULE_03
      disable iff (rst)
      s_read_set |=> (hrdata == {16'h0000, src_ff}))
      else $error("set register read is not the source value");

   chk_clear_blocked: assert property (@(posedge clk_sys) // see RULE_04
      disable iff (rst)
      s_host_clear |=> (($past(src_ff & host_clr.bits & ~permit_ff)
                        & ~src_ff) == 16'h0000))
      else $error("source bit cleared without permission");

   chk_clear_done: assert property (@(posedge clk_sys) // see RULE_05
      disable iff (rst)
      (s_host_clear ##0 !(wph_ff.act && (wph_ff.addr == ADDR_SET)))
      |=> ((src_ff & $past(host_clr.bits & permit_ff)) == 16'h0000))
      else $error("permitted clear did not clear");

   chk_permit_load: assert property (@(posedge clk_sys) // see RULE_05
      disable iff (rst)
      s_permit_write |=> (permit_ff == $past(hwdata[15:0] & SRC_MASK)))
      else $error("permit register did not take the written value");

   // permit bits change only through a register write
   chk_permit_hold: assert property (@(posedge clk_sys) // see RULE_04
      disable iff (rst)
      !(wph_ff.act && (wph_ff.addr == ADDR_PERMIT))
      |=> (permit_ff == $past(permit_ff)))
      else $error("permit register changed without a write");

   chk_read_permit: assert property (@(posedge clk_sys) // see RULE_06
      disable iff (rst)
      s_read_permit |=> (hrdata == {16'h0000, permit_ff}))
      else $error("permit register read is not the permit value");

   chk_reset_zero: assert property (@(posedge clk_sys) // see RULE_06
      $fell(rst) |-> (src_ff == SRC_RST) && (permit_ff == PERMIT_RST))
      else $error("registers not zero after reset");

   chk_bit0_zero: assert property (@(posedge clk_sys) // see RULE_06
      disable iff (rst)
      (src_ff[0] == 1'b0) && (permit_ff[0] == 1'b0))
      else $error("reserved bit 0 is set");

   // ==========================================================
   // bus response and read data
   // ==========================================================
   // hreadyout comes up at the first edge after release, so the
   // check waits until reset was low at the previous edge as well
   chk_ready_up: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(rst) |-> hreadyout)
      else $error("slave not ready after reset");

   chk_resp_okay: assert property (@(posedge clk_sys) disable iff (rst)
      hresp == HRESP_OKAY)
      else $error("slave response is not okay");

   // read data stands until the next read is taken
   chk_rdata_hold: assert property (@(posedge clk_sys)
      disable iff (rst)
      !(req && !hwrite) |=> (hrdata == $past(hrdata)))
      else $error("read data changed without a read");

   chk_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
      hrdata[31:16] == 16'h0000)
      else $error("upper read data bits are not zero");

   // ==========================================================
   // interrupt events
   // ==========================================================
   chk_ev_rise: assert property (@(posedge clk_sys) // see RULE_01
      disable iff (rst)
      (s_set_write ##0 (|(hwdata[15:0] & SRC_MASK & ~src_ff)))
      |=> irq_status[EV_SET_RISE])
      else $error("new source bit did not flag its event");

   chk_ev_blocked: assert property (@(posedge clk_sys) // see RULE_04
      disable iff (rst)
      (s_host_clear ##0 (|(host_clr.bits & ~permit_ff & src_ff
                            & SRC_MASK)))
      |=> irq_status[EV_CLR_BLOCK])
      else $error("refused clear did not flag its event");

   chk_ev_done: assert property (@(posedge clk_sys) // see RULE_05
      disable iff (rst)
      (s_host_clear ##0 (|(host_clr.bits & permit_ff & src_ff
                            & SRC_MASK)))
      |=> irq_status[EV_CLR_DONE])
      else $error("permitted clear did not flag its event");
endmodule
`default_nettype wire

/* File: testbench/eisc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// host side: writes of the interrupt source register
// ==========================================================
module eisc_host_model
   import eisc_pkg::*;
(
   input  wire logic          clk_sys,
   output var  eisc_clr_req_t host_clr
);
   initial host_clr = {1'b0, 16'h0000};
   // one write is a one-cycle pulse; the bits flip after it so that
   // a late sample cannot pass for a real request
   task automatic host_write(input logic [15:0] b);
      @(posedge clk_sys);
      host_clr <= {1'b1, b};
      @(posedge clk_sys);
      host_clr <= {1'b0, ~b};
      #1;
   endtask
endmodule
`default_nettype wire

/* File: testbench/emi_irq_source_set_clear_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// bench for the interrupt source set/clear block
// ==========================================================
module emi_irq_source_set_clear_tb
   import eisc_pkg::*;
;
   logic          clk_sys;
   logic          rst;
   logic          hsel;
   logic          hwrite;
   logic [1:0]    htrans;
   logic [2:0]    hsize;
   logic [31:0]   haddr;
   logic [31:0]   hwdata;
   logic [31:0]   hrdata;
   logic          hreadyout;
   logic          hresp;
   logic [15:0]   irq_source;
   logic          irq;
   logic [31:0]   rd;
   eisc_clr_req_t host_clr;
   int            miscompares = 0;
   int            checked = 0;

   eisc_top u_dut (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .hsel       (hsel),
      .haddr      (haddr),
      .htrans     (htrans),
      .hwrite     (hwrite),
      .hsize      (hsize),
      .hwdata     (hwdata),
      .hready     (hreadyout),
      .hrdata     (hrdata),
      .hreadyout  (hreadyout),
      .hresp      (hresp),
      .host_clr   (host_clr),
      .irq_source (irq_source),
      .irq        (irq)
   );

   eisc_host_model u_host (
      .clk_sys  (clk_sys),
      .host_clr (host_clr)
   );

   // ==========================================================
   // shared tasks
   // ==========================================================
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // single AHB transfer; the master never assumes a latency
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h000000, a};
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
      check({31'h0, hresp}, {31'h0, HRESP_OKAY});
      hwdata <= ~d;
      #1;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h00000000);
      check(rd, exp);
   endtask

   // write then read of one register, back to back on the bus
   task automatic wrrd(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= 1'b1;
      haddr  <= {24'h000000, a};
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hwrite <= 1'b0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= ~d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
      #1;
   endtask

   // irq is registered at the same edge as status and enable
   task automatic irqchk(input logic exp);
      @(posedge clk_sys);
      #1;
      check({31'h0, irq}, {31'h0, exp});
   endtask

   task automatic finish_test();
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================================
   // clock, watchdog and tests
   // ==========================================================
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // the tests need under a hundred cycles; the 1000-cycle limit is ample headroom
   initial begin
      #40000;
      miscompares++;
      finish_test();
   end

   initial begin
      rst    = 1'b1;
      hsel   = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'h2;
      haddr  = 32'h00000000;
      hwdata = 32'h00000000;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rdchk(ADDR_SET, 32'h0);
      rdchk(ADDR_PERMIT, 32'h0);
      ahb(1'b1, ADDR_SET, 32'hFFFF00F1);
      rdchk(ADDR_SET, 32'h00F0);
      ahb(1'b1, ADDR_SET, 32'h00000F00);
      rdchk(ADDR_SET, 32'h0FF0);
      u_host.host_write(16'hFFFF);
      check({16'h0, irq_source}, 32'h0FF0);
      ahb(1'b1, ADDR_PERMIT, 32'hFFFF00FF);
      rdchk(ADDR_PERMIT, 32'h00FE);
      u_host.host_write(16'hFFFF);
      check({16'h0, irq_source}, 32'h0F00);
      rdchk(ADDR_SET, 32'h0F00);
      // every event has fired at least once; enable is still zero, so irq is masked
      rdchk(ADDR_IRQ_ST, 32'h7);
      check({31'h0, irq}, 32'h0);
      ahb(1'b1, ADDR_IRQ_EN, 32'h4);
      irqchk(1'b1);
      ahb(1'b1, ADDR_IRQ_CLR, 32'h4);
      irqchk(1'b0);
      ahb(1'b1, ADDR_IRQ_ST, 32'hFF);
      rdchk(ADDR_IRQ_ST, 32'h3);
      rdchk(ADDR_IRQ_CLR, 32'h0);
      rdchk(8'h40, 32'h0);
      // a reserved bit raises nothing, a new source bit does
      ahb(1'b1, ADDR_SET, 32'h0001);
      irqchk(1'b0);
      ahb(1'b1, ADDR_SET, 32'h0004);
      irqchk(1'b1);
      // a read right behind a write of the same register sees it
      wrrd(ADDR_SET, 32'h00000010);
      check(rd, 32'h0F14);
      wrrd(ADDR_IRQ_EN, 32'h00000003);
      check(rd, 32'h3);
      irqchk(1'b1);
      // reset in mid-run clears set and permit fields
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rdchk(ADDR_SET, 32'h0);
      rdchk(ADDR_PERMIT, 32'h0);
      check({31'h0, irq}, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
